// [src/lpmc_defs.svh]
// constants for the low-power mode controller
`ifndef LPMC_DEFS_SVH
`define LPMC_DEFS_SVH
`define LPMC_SW_W 16
`define LPMC_BIT_CPU_HALT 4
`define LPMC_BIT_OSC_DIS 5
`define LPMC_BIT_CG0 6
`define LPMC_BIT_CG1 7
`define LPMC_BIT_GIE 3
`define LPMC_CODE_ACTIVE 4'h0
`define LPMC_CODE_A 4'h1
`define LPMC_CODE_B 4'h5
`define LPMC_CODE_C 4'h9
`define LPMC_CODE_D 4'hd
`define LPMC_CODE_E 4'hf
`define LPMC_SW_RESET 16'h0000
`endif

// [src/lpmc_pkg.sv]
// types for the low-power mode controller
package lpmc_pkg;
	typedef enum logic [3:0] {
		LPMC_ACTIVE = 4'h0,
		LPMC_MODE_A = 4'h1,
		LPMC_MODE_B = 4'h2,
		LPMC_MODE_C = 4'h3,
		LPMC_MODE_D = 4'h4,
		LPMC_MODE_E = 4'h5,
		LPMC_SHUT_RTC = 4'h6,
		LPMC_SHUT_NOCLK = 4'h7,
		LPMC_UNLISTED = 4'h8
	} lpmc_mode_t;
	typedef struct packed {
		logic [15:0] status_word;
		lpmc_mode_t mode;
		logic cpu_run;
		logic mclk_en;
		logic aclk_en;
		logic sub_main_clock_en;
		logic osc_en;
		logic bias_en;
		logic reg_en;
		logic retain;
		logic pin_freeze;
		logic shut_active;
		logic shut_wake;
	} lpmc_state_t;
endpackage : lpmc_pkg

// [src/lpmc_ctrl.sv]
// low-power mode decode and clock and power gating
// Summary of operation
// - mode chosen from four status bits, clock requests, regulator bit
// - mode saved and restored with status word
// - reloaded word sets mode, even if altered
// - mode bit writes take effect at once
// - peripherals idle while their clock gated
// - retained modes keep pins, ram, registers
// - enabled interrupt wakes retained modes
// - code 1111 plus regulator off: shutdown
// - shutdown entry freezes all port pins
// - no-clock shutdown wakes: power, reset, pins
// - rtc shutdown also wakes on rtc event
// - code 0000 active; sub clock optional
// - active: oscillator on if it sources clock
// - bias on if oscillator on, or if feeding in active and first two modes
// - codes 0001/0101 first, second modes
// - code 1001 third mode, aux only
// - code 1101 fourth mode, aux only
// - code 1111 regulator on: all stopped
// - rtc shutdown keeps rtc clock alive
// - no-clock shutdown stops every source
// - exit clears cg1, osc, cpu and gie bits, keeps cg0
// - clock requests override gating of codes 1001, 1101, 1111 with regulator on
`timescale 1ns/1ns
`include "lpmc_defs.svh"
module lpmc_ctrl
	import lpmc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// status word traffic from the cpu core
	input wire logic sw_write,
	input wire logic [15:0] sw_wdata,
	input wire logic irq_enter,
	input wire logic irq_return,
	input wire logic [15:0] stacked_sw,
	input wire logic irq_pending,
	// configuration of the clock tree
	input wire logic sub_clock_off_bit,
	input wire logic regulator_off_bit,
	input wire logic rtc_select,
	input wire logic osc_feeds_aclk,
	input wire logic osc_feeds_mclk,
	input wire logic osc_feeds_sub_main_clock,
	input wire logic aclk_request,
	input wire logic sub_main_clock_request,
	// wake sources for shutdown
	input wire logic power_cycle,
	input wire logic reset_pin_event,
	input wire logic wake_pin_event,
	input wire logic rtc_event,
	// outputs
	output logic [15:0] status_word,
	output logic [15:0] saved_sw,
	output lpmc_mode_t mode,
	output logic cpu_run,
	output logic mclk_en,
	output logic aclk_en,
	output logic sub_main_clock_en,
	output logic osc_en,
	output logic bias_en,
	output logic reg_en,
	output logic retain,
	output logic pin_freeze,
	output logic shut_wake
);
	lpmc_state_t s_reg;
	lpmc_state_t s_next;
	logic [15:0] save_reg;
	logic [15:0] save_next;
	logic [15:0] sw;
	logic [3:0] code;
	logic low_power;
	logic smc_ok;
	logic wake;

	always_comb begin
		s_next = s_reg;
		save_next = save_reg;
		sw = s_reg.status_word;
		low_power = sw[`LPMC_BIT_CPU_HALT];
		smc_ok = !sub_clock_off_bit;
		// interrupt entry stacks the word and leaves the low-power mode
		if (irq_enter) begin
			save_next = sw;
			if (low_power || s_reg.mode != LPMC_ACTIVE) begin
				sw[`LPMC_BIT_CG1] = 1'b0;
				sw[`LPMC_BIT_OSC_DIS] = 1'b0;
				sw[`LPMC_BIT_CPU_HALT] = 1'b0;
			end
			sw[`LPMC_BIT_GIE] = 1'b0;
		end else if (irq_return) begin
			sw = stacked_sw;
		end else if (sw_write) begin
			sw = sw_wdata;
		end
		// a pending interrupt clears the halt bit only in the cycle of interrupt entry
		if (irq_pending && !s_reg.shut_active)
			sw[`LPMC_BIT_CPU_HALT] = sw[`LPMC_BIT_CPU_HALT] & ~irq_enter;
		code = {sw[`LPMC_BIT_CG1], sw[`LPMC_BIT_CG0], sw[`LPMC_BIT_OSC_DIS], sw[`LPMC_BIT_CPU_HALT]};
		s_next.status_word = sw;
		// shutdown latches until a wake source; core is unpowered meanwhile
		wake = power_cycle | reset_pin_event | wake_pin_event;
		if (s_reg.mode == LPMC_SHUT_RTC)
			wake = wake | rtc_event;
		if (s_reg.shut_active) begin
			// core unpowered: the status word refuses traffic until a wake source; entry still loads saved_sw
			s_next.status_word = s_reg.status_word;
			s_next.shut_wake = wake;
			if (wake) begin
				s_next = '0;
				s_next.status_word = `LPMC_SW_RESET;
				s_next.shut_wake = 1'b1;
				s_next.mode = LPMC_ACTIVE;
			end
		end else begin
			s_next.shut_wake = 1'b0;
			unique case (code)
				`LPMC_CODE_ACTIVE: s_next.mode = LPMC_ACTIVE;
				`LPMC_CODE_A: s_next.mode = LPMC_MODE_A;
				`LPMC_CODE_B: s_next.mode = LPMC_MODE_B;
				`LPMC_CODE_C: s_next.mode = sub_main_clock_request ? LPMC_MODE_A : LPMC_MODE_C;
				`LPMC_CODE_D: s_next.mode = sub_main_clock_request ? LPMC_MODE_B : LPMC_MODE_D;
				`LPMC_CODE_E: begin
					if (regulator_off_bit)
						s_next.mode = rtc_select ? LPMC_SHUT_RTC : LPMC_SHUT_NOCLK;
					else if (sub_main_clock_request)
						s_next.mode = LPMC_MODE_B;
					else if (aclk_request)
						s_next.mode = LPMC_MODE_D;
					else
						s_next.mode = LPMC_MODE_E;
				end
				default: s_next.mode = LPMC_UNLISTED;
			endcase
			s_next.reg_en = 1'b1;
			s_next.retain = 1'b1;
			s_next.pin_freeze = 1'b0;
			s_next.shut_active = 1'b0;
			unique case (s_next.mode)
				LPMC_ACTIVE: begin
					s_next.cpu_run = 1'b1;
					s_next.mclk_en = 1'b1;
					s_next.aclk_en = 1'b1;
					s_next.sub_main_clock_en = smc_ok;
					s_next.osc_en = osc_feeds_aclk | osc_feeds_mclk | (osc_feeds_sub_main_clock & smc_ok);
				end
				LPMC_MODE_A, LPMC_MODE_B: begin
					s_next.cpu_run = 1'b0;
					s_next.mclk_en = 1'b0;
					s_next.aclk_en = 1'b1;
					s_next.sub_main_clock_en = smc_ok;
					s_next.osc_en = osc_feeds_aclk | (osc_feeds_sub_main_clock & smc_ok);
				end
				LPMC_MODE_C, LPMC_MODE_D: begin
					s_next.cpu_run = 1'b0;
					s_next.mclk_en = 1'b0;
					s_next.aclk_en = 1'b1;
					s_next.sub_main_clock_en = 1'b0;
					s_next.osc_en = (s_next.mode == LPMC_MODE_C) & osc_feeds_aclk;
				end
				LPMC_MODE_E: begin
					s_next.cpu_run = 1'b0;
					s_next.mclk_en = 1'b0;
					s_next.aclk_en = 1'b0;
					s_next.sub_main_clock_en = 1'b0;
					s_next.osc_en = 1'b0;
				end
				LPMC_SHUT_RTC, LPMC_SHUT_NOCLK: begin
					// rtc domain is outside this block; aclk_en stands for its source
					s_next.cpu_run = 1'b0;
					s_next.mclk_en = 1'b0;
					s_next.aclk_en = (s_next.mode == LPMC_SHUT_RTC);
					s_next.sub_main_clock_en = 1'b0;
					s_next.osc_en = 1'b0;
					s_next.reg_en = 1'b0;
					s_next.retain = 1'b0;
					s_next.pin_freeze = 1'b1;
					s_next.shut_active = 1'b1;
				end
				default: begin
					s_next.cpu_run = !code[0];
					s_next.mclk_en = !code[0];
					s_next.aclk_en = 1'b1;
					s_next.sub_main_clock_en = !code[3] & smc_ok;
					s_next.osc_en = !code[1] & (osc_feeds_aclk | osc_feeds_mclk | (osc_feeds_sub_main_clock & smc_ok));
				end
			endcase
			// bias also on for osc feeding main or sub clock in active and first two modes only
			if (s_next.mode == LPMC_ACTIVE || s_next.mode == LPMC_MODE_A || s_next.mode == LPMC_MODE_B)
				s_next.bias_en = s_next.osc_en | osc_feeds_mclk | (osc_feeds_sub_main_clock & smc_ok);
			else
				s_next.bias_en = s_next.osc_en;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s_reg <= '{status_word: 16'h0000, mode: LPMC_ACTIVE, cpu_run: 1'b1, mclk_en: 1'b1,
				aclk_en: 1'b1, sub_main_clock_en: 1'b1, osc_en: 1'b1, bias_en: 1'b1, reg_en: 1'b1,
				retain: 1'b1, pin_freeze: 1'b0, shut_active: 1'b0, shut_wake: 1'b0};
			save_reg <= 16'h0000;
		end else begin
			s_reg <= s_next;
			save_reg <= save_next;
		end
	end

	assign status_word = s_reg.status_word;
	assign saved_sw = save_reg;
	assign mode = s_reg.mode;
	assign cpu_run = s_reg.cpu_run;
	assign mclk_en = s_reg.mclk_en;
	assign aclk_en = s_reg.aclk_en;
	assign sub_main_clock_en = s_reg.sub_main_clock_en;
	assign osc_en = s_reg.osc_en;
	assign bias_en = s_reg.bias_en;
	assign reg_en = s_reg.reg_en;
	assign retain = s_reg.retain;
	assign pin_freeze = s_reg.pin_freeze;
	assign shut_wake = s_reg.shut_wake;

	// checks kept beside the logic
	sequence s_enter_irq;
		irq_enter && !s_reg.shut_active;
	endsequence
	sequence s_cleared_bits;
		!status_word[`LPMC_BIT_CPU_HALT] && !status_word[`LPMC_BIT_CG1] && !status_word[`LPMC_BIT_OSC_DIS];
	endsequence

	a_exit_clear_bits: assert property (@(posedge mclk) disable iff (reset)
		s_enter_irq |=> s_cleared_bits)
		else $error("mode bits not cleared on interrupt entry");
	a_save_word: assert property (@(posedge mclk) disable iff (reset)
		s_enter_irq |=> saved_sw == $past(status_word))
		else $error("status word not saved on entry");
	a_reload_word: assert property (@(posedge mclk) disable iff (reset)
		(irq_return && !irq_enter && !irq_pending && !s_reg.shut_active) |=> status_word == $past(stacked_sw))
		else $error("reloaded word not adopted");
	a_active_gates: assert property (@(posedge mclk) disable iff (reset)
		(mode == LPMC_ACTIVE && !s_reg.shut_wake) |-> cpu_run && mclk_en && aclk_en)
		else $error("active mode gating wrong");
	a_mode_e_off: assert property (@(posedge mclk) disable iff (reset)
		mode == LPMC_MODE_E |-> !cpu_run && !mclk_en && !aclk_en && !sub_main_clock_en && !osc_en)
		else $error("fifth mode left a clock running");
	a_shut_power: assert property (@(posedge mclk) disable iff (reset)
		(mode == LPMC_SHUT_RTC || mode == LPMC_SHUT_NOCLK) |-> !reg_en && !retain && pin_freeze)
		else $error("shutdown did not remove power");
	a_noclk_dark: assert property (@(posedge mclk) disable iff (reset)
		mode == LPMC_SHUT_NOCLK |-> !aclk_en && !osc_en && !sub_main_clock_en)
		else $error("clock alive in no-clock shutdown");
	a_noclk_rtc_ignored: assert property (@(posedge mclk) disable iff (reset)
		(mode == LPMC_SHUT_NOCLK && rtc_event && !power_cycle && !reset_pin_event && !wake_pin_event)
		|=> mode == LPMC_SHUT_NOCLK)
		else $error("rtc event woke no-clock shutdown");
	a_rtc_wake: assert property (@(posedge mclk) disable iff (reset)
		(mode == LPMC_SHUT_RTC && rtc_event) |=> shut_wake && mode == LPMC_ACTIVE)
		else $error("rtc event did not wake rtc shutdown");
	a_write_now: assert property (@(posedge mclk) disable iff (reset)
		(sw_write && !irq_enter && !irq_return && !irq_pending && !s_reg.shut_active
			&& sw_wdata[7:4] == `LPMC_CODE_C && !sub_main_clock_request) |=> mode == LPMC_MODE_C && !sub_main_clock_en)
		else $error("mode write not immediate");
	a_first_modes: assert property (@(posedge mclk) disable iff (reset)
		(mode == LPMC_MODE_A || mode == LPMC_MODE_B) |-> !cpu_run && !mclk_en && aclk_en)
		else $error("first or second mode gating wrong");
	a_third_mode: assert property (@(posedge mclk) disable iff (reset)
		mode == LPMC_MODE_C |-> !cpu_run && !mclk_en && aclk_en && !sub_main_clock_en)
		else $error("third mode gating wrong");
	a_fourth_mode: assert property (@(posedge mclk) disable iff (reset)
		mode == LPMC_MODE_D |-> !cpu_run && !mclk_en && aclk_en && !sub_main_clock_en && !osc_en)
		else $error("fourth mode gating wrong");
	a_retain_kept: assert property (@(posedge mclk) disable iff (reset)
		(mode != LPMC_SHUT_RTC && mode != LPMC_SHUT_NOCLK && !shut_wake) |-> retain && reg_en && !pin_freeze)
		else $error("retained mode lost power");
	a_rtc_alive: assert property (@(posedge mclk) disable iff (reset)
		mode == LPMC_SHUT_RTC |-> aclk_en && !reg_en)
		else $error("rtc source stopped in rtc shutdown");
	a_bias_follows: assert property (@(posedge mclk) disable iff (reset)
		((mode == LPMC_ACTIVE || mode == LPMC_MODE_A || mode == LPMC_MODE_B) && osc_en) |-> bias_en)
		else $error("bias off with oscillator on");
	a_osc_active: assert property (@(posedge mclk) disable iff (reset)
		(mode == LPMC_ACTIVE && !shut_wake && $past(osc_feeds_aclk)) |-> osc_en)
		else $error("oscillator off while sourcing aux clock");
	a_irq_wakes: assert property (@(posedge mclk) disable iff (reset)
		s_enter_irq |=> cpu_run)
		else $error("interrupt did not wake the core");
	a_noclk_hold: assert property (@(posedge mclk) disable iff (reset)
		(mode == LPMC_SHUT_NOCLK && !power_cycle && !reset_pin_event && !wake_pin_event)
		|=> mode == LPMC_SHUT_NOCLK)
		else $error("no-clock shutdown left without wake source");
	a_pin_wake: assert property (@(posedge mclk) disable iff (reset)
		(s_reg.shut_active && wake_pin_event) |=> shut_wake && mode == LPMC_ACTIVE)
		else $error("wake pin did not end shutdown");
	a_unlisted_bits: assert property (@(posedge mclk) disable iff (reset)
		mode == LPMC_UNLISTED |-> aclk_en && (cpu_run == !status_word[`LPMC_BIT_CPU_HALT]))
		else $error("unlisted code not gated bit by bit");
	a_fifth_code: assert property (@(posedge mclk) disable iff (reset)
		mode == LPMC_MODE_E |-> status_word[7:4] == `LPMC_CODE_E)
		else $error("fifth mode without its code");
endmodule : lpmc_ctrl

// [tb/lpmc_core_model.sv]
// cpu core side: interrupt entry, stacked status word, return
`timescale 1ns/1ns
module lpmc_core_model
	import lpmc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// commands from the bench
	input wire logic take_irq,
	input wire logic give_ret,
	input wire logic [15:0] isr_clear,
	// live word from the controller
	input wire logic [15:0] status_word,
	// core side of the controller
	output logic irq_enter,
	output logic irq_return,
	output logic [15:0] stacked_sw
);
	logic [15:0] stack_reg;
	assign irq_enter = take_irq;
	assign irq_return = give_ret;
	// stale stack slot shows inverted, so a read outside return is never mistaken for data
	assign stacked_sw = give_ret ? stack_reg : ~stack_reg;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			stack_reg <= 16'h0000;
		end else if (irq_enter) begin
			stack_reg <= status_word & ~isr_clear;
		end
	end
endmodule : lpmc_core_model

// [tb/tb.sv]
// self-checking bench for the low-power mode controller
`timescale 1ns/1ns
module tb;
	import lpmc_pkg::*;
	logic mclk = 1'b0, reset = 1'b1, sw_write = 1'b0, irq_pending = 1'b0, sub_clock_off_bit = 1'b0;
	logic regulator_off_bit = 1'b0, rtc_select = 1'b0, osc_feeds_aclk = 1'b0, osc_feeds_mclk = 1'b0;
	logic osc_feeds_sub_main_clock = 1'b0, aclk_request = 1'b0, sub_main_clock_request = 1'b0, power_cycle = 1'b0;
	logic reset_pin_event = 1'b0, wake_pin_event = 1'b0, rtc_event = 1'b0, take_irq = 1'b0, give_ret = 1'b0;
	logic [15:0] sw_wdata = 16'h0000, isr_clear = 16'h00c0, stacked_sw, status_word, saved_sw;
	logic irq_enter, irq_return, cpu_run, mclk_en, aclk_en, sub_main_clock_en, osc_en, bias_en, reg_en;
	logic retain, pin_freeze, shut_wake;
	lpmc_mode_t mode;
	int bad_count = 0, num_checks = 0, cycles = 0;
	// row: word bits 7:0, osc feeds main clock, mode, cpu, aux, sub, osc, bias
	logic [17:0] rows [8] = '{{8'h00, 1'b1, 4'h0, 5'b11111}, {8'h10, 1'b1, 4'h1, 5'b01101},
		{8'h50, 1'b0, 4'h2, 5'b01100}, {8'h90, 1'b0, 4'h3, 5'b01000}, {8'hd0, 1'b0, 4'h4, 5'b01000},
		{8'hf0, 1'b0, 4'h5, 5'b00000}, {8'h00, 1'b0, 4'h0, 5'b11100}, {8'h30, 1'b0, 4'h8, 5'b01100}};
	always #4 mclk = ~mclk;
	lpmc_core_model core (.mclk(mclk), .reset(reset), .take_irq(take_irq), .give_ret(give_ret),
		.isr_clear(isr_clear), .status_word(status_word), .irq_enter(irq_enter),
		.irq_return(irq_return), .stacked_sw(stacked_sw));
	lpmc_ctrl uut (.mclk(mclk), .reset(reset), .sw_write(sw_write), .sw_wdata(sw_wdata),
		.irq_enter(irq_enter), .irq_return(irq_return), .stacked_sw(stacked_sw),
		.irq_pending(irq_pending), .sub_clock_off_bit(sub_clock_off_bit),
		.regulator_off_bit(regulator_off_bit), .rtc_select(rtc_select), .osc_feeds_aclk(osc_feeds_aclk),
		.osc_feeds_mclk(osc_feeds_mclk), .osc_feeds_sub_main_clock(osc_feeds_sub_main_clock), .aclk_request(aclk_request),
		.sub_main_clock_request(sub_main_clock_request), .power_cycle(power_cycle), .reset_pin_event(reset_pin_event),
		.wake_pin_event(wake_pin_event), .rtc_event(rtc_event), .status_word(status_word),
		.saved_sw(saved_sw), .mode(mode), .cpu_run(cpu_run), .mclk_en(mclk_en), .aclk_en(aclk_en),
		.sub_main_clock_en(sub_main_clock_en), .osc_en(osc_en), .bias_en(bias_en), .reg_en(reg_en), .retain(retain),
		.pin_freeze(pin_freeze), .shut_wake(shut_wake));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [7:0] d);
		@(posedge mclk);
		sw_write <= 1'b1;
		sw_wdata <= {8'h00, d};
		@(posedge mclk);
		sw_write <= 1'b0;
		@(negedge mclk);
	endtask : wr
	task close_out();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// a hang stops here rather than running on
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		@(negedge mclk);
		chk(status_word, 16'h0000);
		chk(16'({mode, cpu_run, reg_en, retain, pin_freeze}), 16'h0e);
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		foreach (rows[i]) begin
			osc_feeds_mclk <= rows[i][9];
			wr(rows[i][17:10]);
			chk(16'({mode, cpu_run, aclk_en, sub_main_clock_en, osc_en, bias_en}), 16'(rows[i][8:0]));
		end
		aclk_request <= 1'b1;
		wr(8'hf0);
		chk(16'({mode, aclk_en}), 16'h09);
		aclk_request <= 1'b0;
		sub_main_clock_request <= 1'b1;
		wr(8'h90);
		chk(16'({mode, sub_main_clock_en}), 16'h03);
		chk(16'({mclk_en, cpu_run}), 16'h0000);
		sub_main_clock_request <= 1'b0;
		wr(8'hd8);
		@(posedge mclk);
		take_irq <= 1'b1;
		@(posedge mclk);
		take_irq <= 1'b0;
		@(negedge mclk);
		chk(saved_sw, 16'h00d8);
		chk(status_word, 16'h0040);
		@(posedge mclk);
		give_ret <= 1'b1;
		@(posedge mclk);
		give_ret <= 1'b0;
		@(negedge mclk);
		chk(16'({status_word, mode}), 16'h0181);
		regulator_off_bit <= 1'b1;
		wr(8'hf0);
		chk(16'({mode, reg_en, retain, pin_freeze, aclk_en}), 16'h0072);
		// neither rtc nor an interrupt may wake the no-clock flavour
		rtc_event <= 1'b1;
		irq_pending <= 1'b1;
		wr(8'h00);
		chk(16'({mode, shut_wake}), 16'h0e);
		chk(status_word, 16'h00f0);
		rtc_event <= 1'b0;
		irq_pending <= 1'b0;
		wake_pin_event <= 1'b1;
		@(posedge mclk);
		wake_pin_event <= 1'b0;
		@(negedge mclk);
		chk(16'({mode, shut_wake}), 16'h01);
		rtc_select <= 1'b1;
		wr(8'hf0);
		chk(16'({mode, reg_en, aclk_en}), 16'h19);
		@(posedge mclk);
		rtc_event <= 1'b1;
		@(posedge mclk);
		rtc_event <= 1'b0;
		@(negedge mclk);
		chk(16'({mode, shut_wake}), 16'h01);
		close_out();
	end
endmodule : tb
